// file: crpsu_pkg.sv
// package: constants, role codes and timing for the cold-redundancy psu control block
// assumes a 25 MHz clock; analog comparators and sensors deliver synchronous levels
// Function
// R1: over-temperature turns the main output off.
// R2: main output restores itself when temperature recovers; standby rail stays on.
// R3: trip and recovery use separate thresholds at least 4 C apart; code sets recovery to 0 when trip is below 4.
// R4: in cold redundancy only the needed supply is on, others in cold standby.
// R5: pull shared wire low on any fault or output below fault threshold.
// R6: low shared wire turns a standby supply on within 100 us.
// R7: without an active supply holding the wire high, output stays on.
// R8: before any role is assigned the output is on.
// R9: standby allowed only while some supply is active or standard redundant.
// R10: active roles keep output on, ignore load share, drive wire high when healthy.
// R11: standby positions 1..3 use codes 02h..04h and leave wire open when healthy.
// R12: standby turns on when load share exceeds its enable threshold.
// R13: standby turns off below its position's disable threshold.
// R14: after turning on, comparison switches to the lower disable threshold.
// R15: normal standby on/off decided only from own load share sensing.
// R16: system controller assigns positions at power-on, failure and insertion.
// R17: threshold levels are programmed by the system over a command.
// R18: load share level scales so 8.0 V is full rated power.
// R19: led green on, off without ac, 1 Hz green for standby or cold state.
// R20: led 1 Hz amber on warning, steady amber on critical or lost ac.
// R21: led 2 Hz green during firmware update.
// R22: blink rates from clock dividers, 50 percent duty, faults take priority.
package crpsu_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned WAKE_TIME_NS = 100000;
  localparam int unsigned WAKE_CYCLES = (WAKE_TIME_NS / 1000) * (CLK_HZ / 1000000);
  localparam int unsigned BLINK1_HALF_CYCLES = CLK_HZ / 2;
  localparam int unsigned BLINK2_HALF_CYCLES = CLK_HZ / 4;
  localparam int unsigned OTP_MARGIN_C = 4;
  // load share codes in millivolts, 8000 mV is full rated power
  localparam logic [13:0] SHARE_FULL_MV = 14'h1F40;
  localparam logic [13:0] EN_POS1_MV = 14'h0C80;
  localparam logic [13:0] EN_POS2_MV = 14'h1388;
  localparam logic [13:0] EN_POS3_MV = 14'h1A2C;
  localparam logic [13:0] DIS_POS1_MV = 14'h05A0;
  localparam logic [13:0] DIS_POS2_MV = 14'h0BC2;
  localparam logic [13:0] DIS_POS3_MV = 14'h11A8;
  localparam logic [7:0] ROLE_UNASSIGNED = 8'h00;
  localparam logic [7:0] ROLE_STANDARD = 8'h01;
  localparam logic [7:0] ROLE_STANDBY1 = 8'h02;
  localparam logic [7:0] ROLE_STANDBY2 = 8'h03;
  localparam logic [7:0] ROLE_STANDBY3 = 8'h04;
  localparam logic [7:0] ROLE_ACTIVE = 8'h05;
  localparam logic [31:0] ADDR_ROLE = 32'h0000_0000;
  localparam logic [31:0] ADDR_EN_TH = 32'h0000_0004;
  localparam logic [31:0] ADDR_DIS_TH = 32'h0000_0008;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_000C;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
  localparam logic [7:0] OTP_TRIP_C_RST = 8'h5A;
  localparam logic [7:0] OTP_CLEAR_C_RST = 8'h50;
  localparam logic [31:0] ADDR_OTP = 32'h0000_0014;
  typedef enum logic [1:0] {
    CRPSU_ON_DEFAULT = 2'b00,
    CRPSU_STBY_OFF = 2'b01,
    CRPSU_STBY_ON = 2'b10,
    CRPSU_WAKE = 2'b11
  } crpsu_state_t;
  typedef enum logic [1:0] {
    CRPSU_LED_OFF = 2'b00,
    CRPSU_LED_GREEN = 2'b01,
    CRPSU_LED_AMBER = 2'b10
  } crpsu_led_t;
endpackage

// file: crpsu_ctrl.sv
// top: main output enable, shared wake wire driver, led encoder and apb registers
// assumes synchronous comparator and sensor levels, wire level read back from the pin
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
module crpsu_ctrl (
  input wire logic clock_i, // 25 MHz clock
  input wire logic reset_i, // async reset, active high
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb write
  input wire logic [31:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error on unmapped address
  input wire logic [7:0] temp_c_i, // ambient temperature, deg C
  input wire logic [13:0] share_mv_i, // load share level, mV
  input wire logic vout_low_i, // output below fault threshold
  input wire logic fault_i, // own supply fault
  input wire logic critical_i, // critical shutdown event
  input wire logic warning_i, // non-fatal warning
  input wire logic ac_ok_i, // own ac present
  input wire logic partner_ac_i, // some partner supply has ac
  input wire logic fw_update_i, // firmware update in progress
  input wire logic wake_wire_i, // level on shared standby wake wire
  output logic wake_wire_o, // wake wire drive value
  output logic wake_wire_oe_o, // wake wire drive enable
  output logic main_on_o, // main output enable
  output logic standby_rail_o, // standby rail enable
  output logic led_green_o, // green led
  output logic led_amber_o // amber led
);
  logic [7:0] role_q, role_d;
  logic [13:0] en_th_q, en_th_d, dis_th_q, dis_th_d;
  logic custom_th_q, custom_th_d;
  logic [7:0] trip_q, trip_d, clr_q, clr_d;
  logic otp_q, otp_d;
  crpsu_pkg::crpsu_state_t st_q, st_d;
  logic [11:0] wake_cnt_q, wake_cnt_d;
  logic [24:0] b1_q, b1_d, b2_q, b2_d;
  logic ph1_q, ph1_d, ph2_q, ph2_d;
  logic main_q, main_d, wo_q, wo_d, woe_q, woe_d, g_q, g_d, a_q, a_d;
  logic [31:0] rd_q, rd_d;
  logic rdy_q, rdy_d, err_q, err_d;
  logic rail_q;

  function automatic logic is_standby(input logic [7:0] r);
    is_standby = (r == crpsu_pkg::ROLE_STANDBY1) || (r == crpsu_pkg::ROLE_STANDBY2) ||
                 (r == crpsu_pkg::ROLE_STANDBY3);
  endfunction

  function automatic logic [13:0] pos_th(input logic [7:0] r, input logic dis);
    logic [13:0] v;
    v = dis ? crpsu_pkg::DIS_POS1_MV : crpsu_pkg::EN_POS1_MV;
    if (r == crpsu_pkg::ROLE_STANDBY2) begin
      v = dis ? crpsu_pkg::DIS_POS2_MV : crpsu_pkg::EN_POS2_MV;
    end else if (r == crpsu_pkg::ROLE_STANDBY3) begin
      v = dis ? crpsu_pkg::DIS_POS3_MV : crpsu_pkg::EN_POS3_MV;
    end
    pos_th = v;
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a == crpsu_pkg::ADDR_ROLE) || (a == crpsu_pkg::ADDR_EN_TH) ||
             (a == crpsu_pkg::ADDR_DIS_TH) || (a == crpsu_pkg::ADDR_CTRL) ||
             (a == crpsu_pkg::ADDR_STATUS) || (a == crpsu_pkg::ADDR_OTP);
  endfunction

  logic sick;
  logic [13:0] en_use, dis_use;
  logic access;
  assign sick = fault_i || vout_low_i || otp_q || critical_i;
  // R18: share input in mV, 8000 is full rated power
  // R17: programmed thresholds override the example set
  assign en_use = custom_th_q ? en_th_q : pos_th(role_q, 1'b0);
  assign dis_use = custom_th_q ? dis_th_q : pos_th(role_q, 1'b1);
  assign access = psel_i && penable_i && !rdy_q;

  // apb slave, one wait state: ready one cycle after access starts
  always_comb begin
    role_d = role_q;
    en_th_d = en_th_q;
    dis_th_d = dis_th_q;
    custom_th_d = custom_th_q;
    trip_d = trip_q;
    clr_d = clr_q;
    rd_d = rd_q;
    rdy_d = access;
    err_d = access && !mapped(paddr_i);
    if (access && pwrite_i) begin
      unique case (paddr_i)
        crpsu_pkg::ADDR_ROLE: role_d = pwdata_i[7:0];
        crpsu_pkg::ADDR_EN_TH: en_th_d = pwdata_i[13:0];
        crpsu_pkg::ADDR_DIS_TH: dis_th_d = pwdata_i[13:0];
        crpsu_pkg::ADDR_CTRL: custom_th_d = pwdata_i[0];
        crpsu_pkg::ADDR_OTP: begin
          trip_d = pwdata_i[7:0];
          // R3: recovery point kept at least the margin below trip, or at 0 when trip is below the margin
          // nine-bit sum so a clear point near 255 cannot wrap past the check
          if ({1'b0, pwdata_i[15:8]} + {1'b0, crpsu_pkg::OTP_MARGIN_C[7:0]} <= {1'b0, pwdata_i[7:0]}) begin
            clr_d = pwdata_i[15:8];
          end else if (pwdata_i[7:0] >= crpsu_pkg::OTP_MARGIN_C[7:0]) begin
            clr_d = pwdata_i[7:0] - crpsu_pkg::OTP_MARGIN_C[7:0];
          end else begin
            clr_d = 8'h00;
          end
        end
        default: ;
      endcase
    end
    if (access && !pwrite_i) begin
      unique case (paddr_i)
        crpsu_pkg::ADDR_ROLE: rd_d = {24'h000000, role_q};
        crpsu_pkg::ADDR_EN_TH: rd_d = {18'h00000, en_th_q};
        crpsu_pkg::ADDR_DIS_TH: rd_d = {18'h00000, dis_th_q};
        crpsu_pkg::ADDR_CTRL: rd_d = {31'h00000000, custom_th_q};
        crpsu_pkg::ADDR_STATUS: rd_d = {26'h0000000, st_q, wake_wire_i, otp_q, main_q, sick};
        crpsu_pkg::ADDR_OTP: rd_d = {16'h0000, clr_q, trip_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // R1: trip turns output off  R2: clears on recovery, hysteresis keeps it stable
  always_comb begin
    otp_d = otp_q;
    if (temp_c_i >= trip_q) begin
      otp_d = 1'b1;
    end else if (temp_c_i <= clr_q) begin
      otp_d = 1'b0;
    end
  end

  // role state machine
  always_comb begin
    st_d = st_q;
    wake_cnt_d = 12'h000;
    unique case (st_q)
      crpsu_pkg::CRPSU_ON_DEFAULT: begin
        // R8: on until a standby role is assigned  R9: and an active supply holds the wire high
        if (is_standby(role_q) && wake_wire_i) begin
          st_d = crpsu_pkg::CRPSU_STBY_OFF;
        end
      end
      crpsu_pkg::CRPSU_STBY_OFF: begin
        if (!is_standby(role_q)) begin
          st_d = crpsu_pkg::CRPSU_ON_DEFAULT;
        end else if (!wake_wire_i) begin
          // R6: low wire wakes standby at once, well inside 100 us
          st_d = crpsu_pkg::CRPSU_WAKE;
        end else if (share_mv_i > en_use) begin
          // R12: enable threshold crossed  R15: own sensing only
          st_d = crpsu_pkg::CRPSU_STBY_ON;
        end
      end
      crpsu_pkg::CRPSU_STBY_ON: begin
        if (!is_standby(role_q)) begin
          st_d = crpsu_pkg::CRPSU_ON_DEFAULT;
        end else if (!wake_wire_i) begin
          st_d = crpsu_pkg::CRPSU_WAKE;
        end else if (share_mv_i < dis_use) begin
          // R13: below disable threshold  R14: lower threshold once on
          st_d = crpsu_pkg::CRPSU_STBY_OFF;
        end
      end
      crpsu_pkg::CRPSU_WAKE: begin
        // R7: stays on while nobody holds the wire high; short settle before re-arming
        wake_cnt_d = wake_cnt_q;
        if (!is_standby(role_q)) begin
          st_d = crpsu_pkg::CRPSU_ON_DEFAULT;
        end else if (!wake_wire_i) begin
          wake_cnt_d = 12'h000;
        end else if (wake_cnt_q == crpsu_pkg::WAKE_CYCLES[11:0]) begin
          st_d = crpsu_pkg::CRPSU_STBY_ON;
        end else begin
          wake_cnt_d = wake_cnt_q + 12'h001;
        end
      end
    endcase
  end

  // outputs and led
  always_comb begin
    b1_d = b1_q + 25'h0000001;
    ph1_d = ph1_q;
    b2_d = b2_q + 25'h0000001;
    ph2_d = ph2_q;
    // R22: half-period dividers give 50 percent duty
    if (b1_q == crpsu_pkg::BLINK1_HALF_CYCLES[24:0] - 25'h0000001) begin
      b1_d = 25'h0000000;
      ph1_d = !ph1_q;
    end
    if (b2_q == crpsu_pkg::BLINK2_HALF_CYCLES[24:0] - 25'h0000001) begin
      b2_d = 25'h0000000;
      ph2_d = !ph2_q;
    end
    // R4: only supplies not in cold standby-off deliver  R1: otp and faults force off
    main_d = (st_d != crpsu_pkg::CRPSU_STBY_OFF) && !otp_q && !critical_i && !fault_i && ac_ok_i;
    // R5: any fault pulls the wire low
    if (sick) begin
      wo_d = 1'b0;
      woe_d = 1'b1;
    end else if (is_standby(role_q)) begin
      // R11: healthy standby leaves the wire open
      wo_d = 1'b0;
      woe_d = 1'b0;
    end else if (role_q == crpsu_pkg::ROLE_STANDARD || role_q == crpsu_pkg::ROLE_ACTIVE) begin
      // R10: healthy active supply drives the wire high
      wo_d = 1'b1;
      woe_d = 1'b1;
    end else begin
      wo_d = 1'b0;
      woe_d = 1'b0;
    end
    // R20: critical or lost ac with partner first  R22: faults over warnings
    if (critical_i || otp_q || fault_i || (!ac_ok_i && partner_ac_i)) begin
      g_d = 1'b0;
      a_d = 1'b1;
    end else if (!ac_ok_i) begin
      // R19: no ac anywhere, led off
      g_d = 1'b0;
      a_d = 1'b0;
    end else if (warning_i) begin
      g_d = 1'b0;
      a_d = ph1_q;
    end else if (fw_update_i) begin
      // R21: 2 Hz green
      g_d = ph2_q;
      a_d = 1'b0;
    end else if (!main_q || st_q == crpsu_pkg::CRPSU_STBY_OFF) begin
      // R19: standby only or cold state blinks 1 Hz
      g_d = ph1_q;
      a_d = 1'b0;
    end else begin
      g_d = 1'b1;
      a_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      role_q <= crpsu_pkg::ROLE_UNASSIGNED;
      en_th_q <= crpsu_pkg::EN_POS1_MV;
      dis_th_q <= crpsu_pkg::DIS_POS1_MV;
      custom_th_q <= 1'b0;
      trip_q <= crpsu_pkg::OTP_TRIP_C_RST;
      clr_q <= crpsu_pkg::OTP_CLEAR_C_RST;
      otp_q <= 1'b0;
      st_q <= crpsu_pkg::CRPSU_ON_DEFAULT;
      wake_cnt_q <= 12'h000;
      b1_q <= 25'h0000000;
      b2_q <= 25'h0000000;
      ph1_q <= 1'b0;
      ph2_q <= 1'b0;
      main_q <= 1'b1;
      wo_q <= 1'b0;
      woe_q <= 1'b0;
      g_q <= 1'b0;
      a_q <= 1'b0;
      rd_q <= 32'h00000000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rail_q <= 1'b1;
    end else begin
      role_q <= role_d;
      en_th_q <= en_th_d;
      dis_th_q <= dis_th_d;
      custom_th_q <= custom_th_d;
      trip_q <= trip_d;
      clr_q <= clr_d;
      otp_q <= otp_d;
      st_q <= st_d;
      wake_cnt_q <= wake_cnt_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      ph1_q <= ph1_d;
      ph2_q <= ph2_d;
      main_q <= main_d;
      wo_q <= wo_d;
      woe_q <= woe_d;
      g_q <= g_d;
      a_q <= a_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      rail_q <= 1'b1;
    end
  end

  // R2: standby rail stays on throughout
  assign standby_rail_o = rail_q;
  assign main_on_o = main_q;
  assign wake_wire_o = wo_q;
  assign wake_wire_oe_o = woe_q;
  assign led_green_o = g_q;
  assign led_amber_o = a_q;
  assign prdata_o = rd_q;
  assign pready_o = rdy_q;
  assign pslverr_o = err_q;
endmodule

// file: crpsu_ctrl_assertions.sv
// checker: port relations of the cold-redundancy control block
// assumes default otp thresholds and the registered latencies at the ports
module crpsu_ctrl_assertions (
  input wire logic clock_i, // clock
  input wire logic reset_i, // reset
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pready_o, // apb ready
  input wire logic pslverr_o, // apb error
  input wire logic [31:0] prdata_o, // apb read data
  input wire logic [7:0] temp_c_i, // temperature
  input wire logic fault_i, // own fault
  input wire logic vout_low_i, // output low
  input wire logic critical_i, // critical event
  input wire logic ac_ok_i, // own ac
  input wire logic partner_ac_i, // partner ac
  input wire logic wake_wire_i, // wire level
  input wire logic wake_wire_o, // wire value
  input wire logic wake_wire_oe_o, // wire enable
  input wire logic main_on_o, // main output
  input wire logic standby_rail_o, // standby rail
  input wire logic led_green_o, // green led
  input wire logic led_amber_o // amber led
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  AST_APB_ANSWER: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb access not answered in one cycle");
  AST_PREADY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  AST_ERR_NODATA: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0000_0000)
    else $error("error response without ready or with data");
  AST_OTP_OFF: assert property ((temp_c_i >= 8'h5A)[*2] |=> !main_on_o)
    else $error("main output on during over-temperature");
  AST_RAIL_ON: assert property (standby_rail_o)
    else $error("standby rail dropped");
  AST_FAULT_WIRE: assert property ((fault_i || vout_low_i)[*2] |=> wake_wire_oe_o && !wake_wire_o)
    else $error("wake wire not pulled low on fault");
  AST_WAKE_ON: assert property ((!wake_wire_i && !fault_i && !critical_i && ac_ok_i && temp_c_i < 8'h50)[*4]
    |=> main_on_o)
    else $error("main output off while wake wire low");
  AST_CRIT_AMBER: assert property (critical_i[*3] |=> led_amber_o && !led_green_o)
    else $error("critical event not steady amber");
  AST_LOST_AC: assert property ((!ac_ok_i && partner_ac_i)[*3] |=> led_amber_o && !led_green_o)
    else $error("lost ac with partner not steady amber");
  AST_NOAC_OFF: assert property ((!ac_ok_i && !partner_ac_i && !critical_i && !fault_i && temp_c_i < 8'h50)[*3]
    |=> !led_green_o && !led_amber_o)
    else $error("led lit with no ac anywhere");
endmodule

// file: crpsu_peer_model.sv
// partner: one other parallel supply on the shared wake wire, open drain
// assumes the bench resolves the wire with a pull-up
module crpsu_peer_model (
  input wire logic clock_i, // clock
  input wire logic active_i, // peer holds an active role
  input wire logic fail_i, // peer has a fault
  output logic drive_o, // wire drive value
  output logic drive_oe_o // wire drive enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // high when active, low on fault
  always_ff @(posedge clock_i) begin
    drive_oe_o <= active_i || fail_i;
    drive_o <= active_i && !fail_i;
  end
endmodule

// file: crpsu_ctrl_tb_top.sv
// bench: apb reads noted in a queue, otp, led, standby thresholds, wake and fault wire
// assumes the peer model on the wake wire and a pull-up on that wire
module crpsu_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0000_0000, pwdata_i = 32'h0000_0000, prdata_o, rnd = 32'd91407;
  logic pready_o, pslverr_o, vout_low_i = 1'b0, fault_i = 1'b0, critical_i = 1'b0, warning_i = 1'b0;
  logic ac_ok_i = 1'b1, partner_ac_i = 1'b1, fw_update_i = 1'b0, wake_wire_i, wake_wire_o, wake_wire_oe_o;
  logic main_on_o, standby_rail_o, led_green_o, led_amber_o, peer_act = 1'b0, peer_fail = 1'b0, peer_o, peer_oe;
  logic [7:0] temp_c_i = 8'h19;
  logic [13:0] share_mv_i = 14'h0000;
  logic [32:0] notes[$];
  // {critical, ac, partner ac, warning, fw, green, amber, check green, check amber}
  logic [8:0] leds[7] = '{9'h0CB, 9'h1C7, 9'h047, 9'h003, 9'h0E2, 9'h0D1, 9'h0CB};
  logic [7:0] roles[4] = '{crpsu_pkg::ROLE_STANDBY1, crpsu_pkg::ROLE_STANDBY2, crpsu_pkg::ROLE_STANDBY3,
    crpsu_pkg::ROLE_STANDBY1};
  logic [13:0] ens[4] = '{crpsu_pkg::EN_POS1_MV, crpsu_pkg::EN_POS2_MV, crpsu_pkg::EN_POS3_MV, 14'h0800};
  logic [13:0] diss[4] = '{crpsu_pkg::DIS_POS1_MV, crpsu_pkg::DIS_POS2_MV, crpsu_pkg::DIS_POS3_MV, 14'h0400};
  int mismatches = 0, checked = 0, n;
  always #20 clock_i = ~clock_i;
  // open-drain wire, pull-up when nobody pulls low
  assign wake_wire_i = !((wake_wire_oe_o && !wake_wire_o) || (peer_oe && !peer_o));
  crpsu_ctrl DUT (.clock_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .temp_c_i, .share_mv_i, .vout_low_i, .fault_i, .critical_i, .warning_i, .ac_ok_i, .partner_ac_i,
    .fw_update_i, .wake_wire_i, .wake_wire_o, .wake_wire_oe_o, .main_on_o, .standby_rail_o, .led_green_o,
    .led_amber_o);
  crpsu_peer_model peer (.clock_i, .active_i(peer_act), .fail_i(peer_fail), .drive_o(peer_o), .drive_oe_o(peer_oe));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // read results noted by the driver, {pslverr, prdata}
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [32:0] exp);
    int k;
    k = 0;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    if (!wr) notes.push_back(exp);
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1 && ++k < 50);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  always @(posedge clock_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      if (notes.size() == 0) check(33'h0, 33'h1);
      else check({pslverr_o, prdata_o}, notes.pop_front());
    end
  end
  // sampled at the edge, so values settled in the cycle before
  task automatic expect_main(input logic exp);
    repeat (5) @(posedge clock_i);
    check(main_on_o, exp);
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    check({main_on_o, standby_rail_o}, 2'b11);
    apb(1'b0, crpsu_pkg::ADDR_OTP, 32'h0, 33'h0_0000_505A);
    apb(1'b0, 32'h0000_0040, 32'h0, 33'h1_0000_0000);
    temp_c_i <= 8'h5A;
    expect_main(1'b0);
    temp_c_i <= 8'h51;
    expect_main(1'b0);
    temp_c_i <= 8'h50;
    expect_main(1'b1);
    check(standby_rail_o, 1'b1);
    rnd = xs(rnd);
    temp_c_i <= {2'b00, rnd[5:0]};
    foreach (leds[i]) begin
      {critical_i, ac_ok_i, partner_ac_i, warning_i, fw_update_i} <= leds[i][8:4];
      repeat (5) @(posedge clock_i);
      if (leds[i][1]) check(led_green_o, leds[i][3]);
      if (leds[i][0]) check(led_amber_o, leds[i][2]);
    end
    rnd = xs(rnd);
    ens[3] = 14'h0800 + {4'h0, rnd[9:0]};
    peer_act <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      // low share while role and thresholds change, so no early crossing
      share_mv_i <= 14'h0000;
      if (i == 3) begin
        apb(1'b1, crpsu_pkg::ADDR_EN_TH, {18'h0, ens[3]}, 33'h0);
        apb(1'b1, crpsu_pkg::ADDR_DIS_TH, {18'h0, diss[3]}, 33'h0);
        apb(1'b0, crpsu_pkg::ADDR_EN_TH, 32'h0, {19'h0, ens[3]});
        apb(1'b1, crpsu_pkg::ADDR_CTRL, 32'h1, 33'h0);
      end
      apb(1'b1, crpsu_pkg::ADDR_ROLE, {24'h0, roles[i]}, 33'h0);
      share_mv_i <= ens[i];
      expect_main(1'b0);
      check(wake_wire_oe_o, 1'b0);
      share_mv_i <= ens[i] + 14'h0001;
      expect_main(1'b1);
      share_mv_i <= diss[i];
      expect_main(1'b1);
      share_mv_i <= diss[i] - 14'h0001;
      expect_main(1'b0);
    end
    peer_fail <= 1'b1;
    n = 0;
    do @(posedge clock_i); while (main_on_o !== 1'b1 && ++n < 2500);
    check(main_on_o, 1'b1);
    peer_fail <= 1'b0;
    fault_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    check({wake_wire_oe_o, wake_wire_o, main_on_o}, 3'b100);
    fault_i <= 1'b0;
    vout_low_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    check({wake_wire_oe_o, wake_wire_o}, 2'b10);
    vout_low_i <= 1'b0;
    foreach (roles[i]) begin
      if (i < 2) begin
        apb(1'b1, crpsu_pkg::ADDR_ROLE, {24'h0, i ? crpsu_pkg::ROLE_ACTIVE : crpsu_pkg::ROLE_STANDARD}, 33'h0);
        share_mv_i <= 14'h0000;
        expect_main(1'b1);
        check({wake_wire_oe_o, wake_wire_o}, 2'b11);
      end
    end
    stop_test();
  end
  initial begin
    #(40 * 60000);
    mismatches++;
    stop_test();
  end
endmodule
bind crpsu_ctrl crpsu_ctrl_assertions chk (.clock_i, .reset_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
  .prdata_o, .temp_c_i, .fault_i, .vout_low_i, .critical_i, .ac_ok_i, .partner_ac_i, .wake_wire_i, .wake_wire_o,
  .wake_wire_oe_o, .main_on_o, .standby_rail_o, .led_green_o, .led_amber_o);
